// ===== udb_pkg.sv
// constants and types shared by both ends of the endpoint buffer link
`default_nettype none
package udb_pkg;
  // ==================================================================
  // endpoint control word layout
  localparam int DW = 16;
  localparam int RXC_BIT = 15;
  localparam int RXT_BIT = 14;
  localparam int RXS_HI = 13;
  localparam int RXS_LO = 12;
  localparam int CAT_HI = 10;
  localparam int CAT_LO = 9;
  localparam int VAR_BIT = 8;
  localparam int TXC_BIT = 7;
  localparam int TXT_BIT = 6;
  localparam int TXS_HI = 5;
  localparam int TXS_LO = 4;
  localparam int EPA_HI = 3;
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [15:0] DESC_RESET = 16'h0000;

  // ==================================================================
  // endpoint word indices seen through the link
  localparam int AW = 4;
  localparam logic [3:0] IDX_CTRL = 4'h0;
  localparam logic [3:0] IDX_TX0P = 4'h1;
  localparam logic [3:0] IDX_TX0L = 4'h2;
  localparam logic [3:0] IDX_TX1P = 4'h3;
  localparam logic [3:0] IDX_TX1L = 4'h4;
  localparam logic [3:0] IDX_RX0P = 4'h5;
  localparam logic [3:0] IDX_RX0L = 4'h6;
  localparam logic [3:0] IDX_RX1P = 4'h7;
  localparam logic [3:0] IDX_RX1L = 4'h8;

  // ==================================================================
  // controller registers on the AXI4-Lite side
  localparam logic [7:0] OFS_SEL = 8'h00;
  localparam logic [7:0] OFS_WDATA = 8'h04;
  localparam logic [7:0] OFS_RDATA = 8'h08;
  localparam logic [7:0] OFS_RELEASE = 8'h0C;
  localparam logic [7:0] OFS_INIT = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==================================================================
  // enumerations
  typedef enum logic [1:0] {
    ST_DIS = 2'h0,
    ST_STALL = 2'h1,
    ST_NAK = 2'h2,
    ST_VALID = 2'h3
  } udb_state_type;

  typedef enum logic [1:0] {
    CAT_BULK = 2'h0,
    CAT_CTRL = 2'h1,
    CAT_ISO = 2'h2,
    CAT_INTR = 2'h3
  } udb_cat_type;

  typedef enum logic [1:0] {
    HS_NONE = 2'h0,
    HS_ACK = 2'h1,
    HS_NAK = 2'h2,
    HS_STALL = 2'h3
  } udb_hs_type;

  typedef enum logic [1:0] {
    X_IDLE = 2'h0,
    X_BUSY = 2'h1
  } udb_xact_type;
endpackage
`default_nettype wire

// ===== udb_if.sv
// link between the endpoint logic and its firmware-side controller
`default_nettype none
interface udb_if;
  logic ep_wr;
  logic [3:0] ep_waddr;
  logic [15:0] ep_wdata;
  logic [3:0] ep_raddr;
  logic [15:0] ep_rdata;
  logic [15:0] ep_ctrl;

  modport dev_mp(
    input ep_wr, ep_waddr, ep_wdata, ep_raddr,
    output ep_rdata, ep_ctrl
  );
  modport host_mp(
    output ep_wr, ep_waddr, ep_wdata, ep_raddr,
    input ep_rdata, ep_ctrl
  );
endinterface
`default_nettype wire

// ===== udb_desc_table.sv
// buffer descriptor words: pointers and lengths of the four buffers
`default_nettype none
module udb_desc_table #(
  parameter int W = 16,
  parameter int N = 8
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic sw_en,
  input wire logic [2:0] sw_idx,
  input wire logic [W-1:0] sw_data,
  input wire logic hw_en,
  input wire logic [2:0] hw_idx,
  input wire logic [W-1:0] hw_data,
  input wire logic [2:0] rd_a_idx,
  output logic [W-1:0] rd_a_data,
  input wire logic [2:0] rd_b_idx,
  output logic [W-1:0] rd_b_data
);
  logic [W-1:0] mem_q [N];

  assign rd_a_data = mem_q[rd_a_idx];
  assign rd_b_data = mem_q[rd_b_idx];

  // hardware count update wins over a firmware write to the same word
  for (genvar i = 0; i < N; i++) begin : g_word
    wire hw_hit = hw_en && (hw_idx == 3'(i));
    wire sw_hit = sw_en && (sw_idx == 3'(i));
    always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
        mem_q[i] <= W'(udb_pkg::DESC_RESET);
      end else if (hw_hit) begin
        mem_q[i] <= hw_data;
      end else if (sw_hit) begin
        mem_q[i] <= sw_data;
      end
    end
  end
endmodule
`default_nettype wire

// ===== udb_dev_end.sv
// endpoint buffer-swapping logic: the device end of the link
`default_nettype none
module udb_dev_end (
  input wire logic clk,
  input wire logic rst_b,
  udb_if.dev_mp link,
  input wire logic token_valid,
  input wire logic token_dir,
  input wire logic xact_done,
  input wire logic xact_ok,
  input wire logic crc_err,
  input wire logic overrun,
  input wire logic [15:0] rx_count,
  output logic resp_valid,
  output udb_pkg::udb_hs_type resp_hs,
  output logic resp_buf_sel,
  output logic [15:0] resp_buf_ptr,
  output logic resp_data1,
  output logic xact_busy,
  output logic err_pulse
);
  // ==================================================================
  // decode of the control word
  logic [15:0] ctrl_q;
  logic [15:0] ctrl_d;
  logic [15:0] rdata_q;
  logic armed_q;
  logic dir_q;
  logic buf_q;
  logic iso_q;
  udb_pkg::udb_xact_type xs_q;
  logic resp_valid_q;
  udb_pkg::udb_hs_type resp_hs_q;
  logic resp_buf_q;
  logic [15:0] resp_ptr_q;
  logic resp_data1_q;
  logic err_q;

  wire [1:0] rx_state = ctrl_q[udb_pkg::RXS_HI:udb_pkg::RXS_LO];
  wire [1:0] tx_state = ctrl_q[udb_pkg::TXS_HI:udb_pkg::TXS_LO];
  wire [1:0] category = ctrl_q[udb_pkg::CAT_HI:udb_pkg::CAT_LO];
  wire rx_toggle_flag = ctrl_q[udb_pkg::RXT_BIT];
  wire tx_toggle_flag = ctrl_q[udb_pkg::TXT_BIT];
  wire endpoint_variant_bit = ctrl_q[udb_pkg::VAR_BIT];
  wire double_buffer_mode = (category == udb_pkg::CAT_BULK)
    && endpoint_variant_bit;
  wire iso_mode = (category == udb_pkg::CAT_ISO);
  wire swap_mode = double_buffer_mode || iso_mode;

  // ==================================================================
  // token decision
  wire [1:0] tok_state = token_dir ? tx_state : rx_state;
  // hardware flag is the active direction's toggle, the other one is
  // the application's flag
  wire hw_buffer_flag = token_dir ? tx_toggle_flag
    : rx_toggle_flag;
  wire app_buffer_flag = token_dir ? rx_toggle_flag
    : tx_toggle_flag;
  // only a valid state is masked, any other written state stands
  wire conflict = armed_q && (tok_state == udb_pkg::ST_VALID)
    && (hw_buffer_flag == app_buffer_flag);
  wire [1:0] eff_state = conflict ? udb_pkg::ST_NAK : tok_state;
  wire tok_take = token_valid && (xs_q == udb_pkg::X_IDLE);
  wire tok_go = tok_take && (eff_state == udb_pkg::ST_VALID);
  wire tok_buf = swap_mode && hw_buffer_flag;
  wire [3:0] ptr_idx = token_dir
    ? (tok_buf ? udb_pkg::IDX_TX1P : udb_pkg::IDX_TX0P)
    : (tok_buf ? udb_pkg::IDX_RX1P : udb_pkg::IDX_RX0P);
  wire [15:0] ptr_word;
  udb_pkg::udb_hs_type tok_hs;

  always_comb begin
    case (eff_state)
      udb_pkg::ST_VALID: tok_hs = udb_pkg::HS_ACK;
      udb_pkg::ST_NAK: tok_hs = udb_pkg::HS_NAK;
      udb_pkg::ST_STALL: tok_hs = udb_pkg::HS_STALL;
      default: tok_hs = udb_pkg::HS_NONE;
    endcase
    if (iso_mode) begin
      tok_hs = udb_pkg::HS_NONE;
    end
  end

  // ==================================================================
  // transaction end
  wire done_ev = xact_done && (xs_q == udb_pkg::X_BUSY);
  // isochronous reception completes even on CRC error or overrun
  wire completed = xact_ok
    || (iso_q && !dir_q && (crc_err || overrun));
  wire fin = done_ev && completed;
  wire fin_rx = fin && !dir_q;
  wire fin_tx = fin && dir_q;
  // ordinary flow (and the first double-buffered bulk transaction) drops to NAK
  wire go_nak = fin && !iso_q && !armed_q;
  wire cnt_wr = fin_rx;
  wire [3:0] cnt_idx = buf_q ? udb_pkg::IDX_RX1L : udb_pkg::IDX_RX0L;

  // ==================================================================
  // firmware access to the control word
  wire sw_ctrl = link.ep_wr && (link.ep_waddr == udb_pkg::IDX_CTRL);
  wire sw_desc = link.ep_wr && (link.ep_waddr != udb_pkg::IDX_CTRL);
  wire [15:0] tmask = sw_ctrl ? link.ep_wdata : 16'h0000;
  wire [15:0] wd = link.ep_wdata;

  always_comb begin
    ctrl_d = ctrl_q;
    // completion flags: hardware set wins over a firmware clear
    ctrl_d[udb_pkg::RXC_BIT] = fin_rx || (ctrl_q[udb_pkg::RXC_BIT]
      && !(sw_ctrl && !wd[udb_pkg::RXC_BIT]));
    ctrl_d[udb_pkg::TXC_BIT] = fin_tx || (ctrl_q[udb_pkg::TXC_BIT]
      && !(sw_ctrl && !wd[udb_pkg::TXC_BIT]));
    // toggle-only bits, firmware and hardware toggles combine
    ctrl_d[udb_pkg::RXT_BIT] = rx_toggle_flag
      ^ tmask[udb_pkg::RXT_BIT] ^ fin_rx;
    ctrl_d[udb_pkg::TXT_BIT] = tx_toggle_flag
      ^ tmask[udb_pkg::TXT_BIT] ^ fin_tx;
    ctrl_d[udb_pkg::RXS_HI:udb_pkg::RXS_LO] = rx_state
      ^ tmask[udb_pkg::RXS_HI:udb_pkg::RXS_LO];
    ctrl_d[udb_pkg::TXS_HI:udb_pkg::TXS_LO] = tx_state
      ^ tmask[udb_pkg::TXS_HI:udb_pkg::TXS_LO];
    if (go_nak && !dir_q) begin
      ctrl_d[udb_pkg::RXS_HI:udb_pkg::RXS_LO] = udb_pkg::ST_NAK;
    end
    if (go_nak && dir_q) begin
      ctrl_d[udb_pkg::TXS_HI:udb_pkg::TXS_LO] = udb_pkg::ST_NAK;
    end
    if (sw_ctrl) begin
      ctrl_d[udb_pkg::CAT_HI:udb_pkg::VAR_BIT] =
        wd[udb_pkg::CAT_HI:udb_pkg::VAR_BIT];
      ctrl_d[udb_pkg::EPA_HI:0] = wd[udb_pkg::EPA_HI:0];
    end
    ctrl_d[11] = 1'b0;
  end

  wire [15:0] desc_rd;
  udb_desc_table #(.W(16), .N(8)) u_desc (
    .clk(clk),
    .rst_b(rst_b),
    .sw_en(sw_desc),
    .sw_idx(3'(link.ep_waddr - 4'h1)),
    .sw_data(link.ep_wdata),
    .hw_en(cnt_wr),
    .hw_idx(3'(cnt_idx - 4'h1)),
    .hw_data(rx_count),
    .rd_a_idx(3'(ptr_idx - 4'h1)),
    .rd_a_data(ptr_word),
    .rd_b_idx(3'(link.ep_raddr - 4'h1)),
    .rd_b_data(desc_rd)
  );
  wire [15:0] rdata_d = (link.ep_raddr == udb_pkg::IDX_CTRL) ? ctrl_q
    : (link.ep_raddr > udb_pkg::IDX_RX1L) ? 16'h0000 : desc_rd;

  // ==================================================================
  // state
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_q <= udb_pkg::CTRL_RESET;
      rdata_q <= 16'h0000;
    end else begin
      ctrl_q <= ctrl_d;
      rdata_q <= rdata_d;
    end
  end

  // swap flow starts only after the first completion in this mode
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      armed_q <= 1'b0;
    end else if (!double_buffer_mode) begin
      armed_q <= 1'b0;
    end else if (fin) begin
      armed_q <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      xs_q <= udb_pkg::X_IDLE;
      dir_q <= 1'b0;
      buf_q <= 1'b0;
      iso_q <= 1'b0;
    end else begin
      case (xs_q)
        udb_pkg::X_IDLE: begin
          if (tok_go) begin
            xs_q <= udb_pkg::X_BUSY;
            dir_q <= token_dir;
            buf_q <= tok_buf;
            iso_q <= iso_mode;
          end
        end
        udb_pkg::X_BUSY: begin
          if (xact_done) begin
            xs_q <= udb_pkg::X_IDLE;
          end
        end
        default: xs_q <= udb_pkg::X_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      resp_valid_q <= 1'b0;
      resp_hs_q <= udb_pkg::HS_NONE;
      resp_buf_q <= 1'b0;
      resp_ptr_q <= 16'h0000;
      resp_data1_q <= 1'b0;
      err_q <= 1'b0;
    end else begin
      resp_valid_q <= tok_take;
      err_q <= done_ev && crc_err;
      if (tok_take) begin
        resp_hs_q <= tok_hs;
        resp_buf_q <= tok_buf;
        resp_ptr_q <= ptr_word;
        resp_data1_q <= !iso_mode && hw_buffer_flag;
      end
    end
  end

  assign link.ep_ctrl = ctrl_q;
  assign link.ep_rdata = rdata_q;
  assign resp_valid = resp_valid_q;
  assign resp_hs = resp_hs_q;
  assign resp_buf_sel = resp_buf_q;
  assign resp_buf_ptr = resp_ptr_q;
  assign resp_data1 = resp_data1_q;
  assign xact_busy = (xs_q == udb_pkg::X_BUSY);
  assign err_pulse = err_q;
endmodule
`default_nettype wire

// ===== udb_host_end.sv
// firmware-side controller: AXI4-Lite registers driving the link
`default_nettype none
module udb_host_end (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  udb_if.host_mp link
);
  // ==================================================================
  // write channel capture
  logic aw_held_q, w_held_q, awready_q, wready_q, bvalid_q;
  logic [7:0] waddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic [1:0] bresp_q;
  logic [3:0] sel_q;
  logic ep_wr_q;
  logic [3:0] ep_waddr_q;
  logic [15:0] ep_wdata_q;

  wire aw_take = s_axi_awvalid && awready_q;
  wire w_take = s_axi_wvalid && wready_q;
  wire do_write = aw_held_q && w_held_q && !bvalid_q;
  wire aw_held_d = (aw_held_q || aw_take) && !do_write;
  wire w_held_d = (w_held_q || w_take) && !do_write;
  wire bvalid_d = do_write || (bvalid_q && !s_axi_bready);
  // partial writes of the low half are ignored, answered OKAY at a mapped offset
  wire full16 = (wstrb_q[1:0] == 2'h3);
  wire hit_sel = (waddr_q == udb_pkg::OFS_SEL);
  wire hit_wd = (waddr_q == udb_pkg::OFS_WDATA);
  wire hit_rel = (waddr_q == udb_pkg::OFS_RELEASE);
  wire hit_init = (waddr_q == udb_pkg::OFS_INIT);
  wire w_mapped = hit_sel || hit_wd || hit_rel || hit_init;

  // ==================================================================
  // shaping of control-word writes
  wire [15:0] cur = link.ep_ctrl;
  wire [15:0] nw = wdata_q[15:0];
  wire [1:0] ncat = nw[udb_pkg::CAT_HI:udb_pkg::CAT_LO];
  wire n_iso = (ncat == udb_pkg::CAT_ISO);
  wire n_swap = n_iso
    || ((ncat == udb_pkg::CAT_BULK) && nw[udb_pkg::VAR_BIT]);
  wire [1:0] n_rxs = cur[udb_pkg::RXS_HI:udb_pkg::RXS_LO]
    ^ nw[udb_pkg::RXS_HI:udb_pkg::RXS_LO];
  wire [1:0] n_txs = cur[udb_pkg::TXS_HI:udb_pkg::TXS_LO]
    ^ nw[udb_pkg::TXS_HI:udb_pkg::TXS_LO];
  // isochronous state pairs may only become disabled or valid
  wire rx_bad = n_iso && (n_rxs == udb_pkg::ST_NAK
    || n_rxs == udb_pkg::ST_STALL);
  wire tx_bad = n_iso && (n_txs == udb_pkg::ST_NAK
    || n_txs == udb_pkg::ST_STALL);
  wire rx_on = !rx_bad && (n_rxs != udb_pkg::ST_DIS);
  // swap endpoint: while RX is on, a TX state write that leaves TX on is refused
  wire tx_dup = n_swap && rx_on
    && (n_txs != udb_pkg::ST_DIS);
  wire [15:0] shaped = {nw[15:14],
    rx_bad ? 2'h0 : nw[udb_pkg::RXS_HI:udb_pkg::RXS_LO], nw[11:6],
    (tx_bad || tx_dup) ? 2'h0 : nw[udb_pkg::TXS_HI:udb_pkg::TXS_LO],
    nw[3:0]};
  // release keeps flags and fields, toggles only the application flag
  wire rx_dir = (cur[udb_pkg::RXS_HI:udb_pkg::RXS_LO] != udb_pkg::ST_DIS);
  wire [15:0] keep = {1'b1, 3'h0, 1'b0,
    cur[udb_pkg::CAT_HI:udb_pkg::VAR_BIT], 1'b1, 3'h0, cur[3:0]};
  wire [15:0] rel_word = keep | (rx_dir ? 16'h0040
    : 16'h4000);
  // init: toggle only the flags that differ from the wanted values
  wire hw_now = rx_dir ? cur[udb_pkg::RXT_BIT] : cur[udb_pkg::TXT_BIT];
  wire app_now = rx_dir ? cur[udb_pkg::TXT_BIT] : cur[udb_pkg::RXT_BIT];
  wire hw_chg = hw_now ^ wdata_q[0];
  wire app_chg = app_now ^ wdata_q[1];
  wire rx_chg = rx_dir ? hw_chg : app_chg;
  wire tx_chg = rx_dir ? app_chg : hw_chg;
  wire [15:0] init_word = keep | {1'b0, rx_chg, 7'h00, tx_chg,
    6'h00};

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= udb_pkg::RESP_OKAY;
      waddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
    end else begin
      aw_held_q <= aw_held_d;
      w_held_q <= w_held_d;
      awready_q <= !aw_held_d && !bvalid_d;
      wready_q <= !w_held_d && !bvalid_d;
      bvalid_q <= bvalid_d;
      if (do_write) begin
        bresp_q <= w_mapped ? udb_pkg::RESP_OKAY : udb_pkg::RESP_SLVERR;
      end
      if (aw_take) begin
        waddr_q <= {s_axi_awaddr[7:2], 2'h0};
      end
      if (w_take) begin
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
    end
  end

  // ==================================================================
  // link writes
  wire go = do_write && full16;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sel_q <= udb_pkg::IDX_CTRL;
      ep_wr_q <= 1'b0;
      ep_waddr_q <= udb_pkg::IDX_CTRL;
      ep_wdata_q <= 16'h0000;
    end else begin
      ep_wr_q <= go && (hit_wd || hit_rel || hit_init);
      if (go && hit_sel) begin
        sel_q <= wdata_q[3:0];
      end
      if (go && hit_wd) begin
        ep_waddr_q <= sel_q;
        ep_wdata_q <= (sel_q == udb_pkg::IDX_CTRL) ? shaped : nw;
      end
      if (go && (hit_rel || hit_init)) begin
        ep_waddr_q <= udb_pkg::IDX_CTRL;
        ep_wdata_q <= hit_rel ? rel_word : init_word;
      end
    end
  end

  // ==================================================================
  // read channel
  logic arready_q, rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  wire ar_take = s_axi_arvalid && arready_q;
  wire rvalid_d = ar_take || (rvalid_q && !s_axi_rready);
  wire [7:0] ra = {s_axi_araddr[7:2], 2'h0};
  wire r_wo = (ra == udb_pkg::OFS_WDATA) || (ra == udb_pkg::OFS_RELEASE)
    || (ra == udb_pkg::OFS_INIT);
  wire r_mapped = r_wo || (ra == udb_pkg::OFS_SEL)
    || (ra == udb_pkg::OFS_RDATA) || (ra == udb_pkg::OFS_STATUS);
  wire [31:0] rd_word = (ra == udb_pkg::OFS_SEL) ? {28'h0, sel_q}
    : (ra == udb_pkg::OFS_RDATA) ? {16'h0, link.ep_rdata}
    : (ra == udb_pkg::OFS_STATUS) ? {16'h0, link.ep_ctrl}
    : 32'h0000_0000;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= udb_pkg::RESP_OKAY;
    end else begin
      arready_q <= !rvalid_d;
      rvalid_q <= rvalid_d;
      if (ar_take) begin
        rdata_q <= rd_word;
        rresp_q <= r_mapped ? udb_pkg::RESP_OKAY : udb_pkg::RESP_SLVERR;
      end
    end
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign link.ep_wr = ep_wr_q;
  assign link.ep_waddr = ep_waddr_q;
  assign link.ep_wdata = ep_wdata_q;
  assign link.ep_raddr = sel_q;
endmodule
`default_nettype wire

// ===== udb_props.sv
// assertions on the link between the two endpoint ends
`default_nettype none
module udb_props (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ep_wr,
  input wire logic [3:0] ep_waddr,
  input wire logic [15:0] ep_wdata,
  input wire logic [3:0] ep_raddr,
  input wire logic [15:0] ep_rdata,
  input wire logic [15:0] ep_ctrl
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==================================================================
  // link checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  wire logic cw;
  wire logic iso;
  assign cw = ep_wr && (ep_waddr == udb_pkg::IDX_CTRL);
  assign iso = ep_ctrl[10:9] == 2'h2;
  a_rx_tog_wr: assert property (cw |=> ep_ctrl[14] ==
    ($past(ep_ctrl[14]) ^ $past(ep_wdata[14]))) else $error("rx toggle");
  a_tx_tog_wr: assert property (cw |=> ep_ctrl[6] ==
    ($past(ep_ctrl[6]) ^ $past(ep_wdata[6]))) else $error("tx toggle");
  a_done_clear: assert property (cw && !ep_wdata[15] |=>
    !ep_ctrl[15]) else $error("complete flag not cleared");
  a_mode_write: assert property (cw |=>
    ep_ctrl[10:8] == $past(ep_wdata[10:8])) else $error("mode field");
  a_iso_legal: assert property (iso |->
    ep_ctrl[13:12] inside {2'h0, 2'h3} && ep_ctrl[5:4] inside {2'h0, 2'h3})
    else $error("iso state illegal");
  a_iso_valid: assert property (iso && ep_ctrl[5:4] == 2'h3 &&
    !ep_wr |=> ep_ctrl[5:4] == 2'h3) else $error("iso state left valid");
  a_one_dir: assert property (ep_ctrl[10:8] == 3'h1 |->
    ep_ctrl[13:12] == 2'h0 || ep_ctrl[5:4] == 2'h0) else $error("two dirs");
  a_one_flag: assert property (!ep_wr |=>
    !(ep_ctrl[14] != $past(ep_ctrl[14]) && ep_ctrl[6] != $past(ep_ctrl[6])))
    else $error("both toggles moved");
  a_wr_pulse: assert property (ep_wr |=> !ep_wr) else $error("long strobe");
  a_unused_rd: assert property ($past(ep_raddr) > 4'h8 |->
    ep_rdata == 16'h0000) else $error("unused word not zero");
endmodule
`default_nettype wire

// ===== usb_endpoint_double_buffering_test.sv
// self-checking bench: both link ends joined, AXI4-Lite and token stimulus
`default_nettype none
module usb_endpoint_double_buffering_test;
  timeunit 1ns;
  timeprecision 1ps;
  // ==================================================================
  // signals and instances
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr;
  logic token_valid = 1'b0, token_dir = 1'b0, xact_done = 1'b0;
  logic xact_ok = 1'b0, crc_err = 1'b0, overrun = 1'b0;
  logic [15:0] rx_count = 16'h0000, resp_buf_ptr;
  logic resp_valid, resp_buf_sel, resp_data1, err_pulse, xact_busy;
  udb_pkg::udb_hs_type resp_hs;
  int mismatches = 0;
  int check_count = 0;
  udb_if link_bus ();
  always #2 clk = ~clk;
  udb_host_end i_udb_host_end (.clk, .rst_b, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .link(link_bus));
  udb_dev_end i_udb_dev_end (.clk, .rst_b, .link(link_bus), .token_valid,
    .token_dir, .xact_done, .xact_ok, .crc_err, .overrun, .rx_count,
    .resp_valid, .resp_hs, .resp_buf_sel, .resp_buf_ptr, .resp_data1,
    .xact_busy, .err_pulse);
  udb_props i_udb_props (.clk, .rst_b, .ep_wr(link_bus.ep_wr),
    .ep_waddr(link_bus.ep_waddr), .ep_wdata(link_bus.ep_wdata),
    .ep_raddr(link_bus.ep_raddr), .ep_rdata(link_bus.ep_rdata),
    .ep_ctrl(link_bus.ep_ctrl));
  // ==================================================================
  // shared tasks
  task automatic chk(input string n, input logic [31:0] e, g);
    check_count++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {16'h0000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    rr = s_axi_bresp;
  endtask
  task automatic rdr(input logic [7:0] a);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    rd = s_axi_rdata;
    rr = s_axi_rresp;
  endtask
  // control word writes go through the select register first
  task automatic cwr(input logic [15:0] d);
    wr(udb_pkg::OFS_SEL, 16'h0000);
    wr(udb_pkg::OFS_WDATA, d);
  endtask
  task automatic st(input logic [15:0] m, e);
    rdr(udb_pkg::OFS_STATUS);
    chk("ctrl", {16'h0000, e}, rd & {16'h0000, m});
  endtask
  task automatic dsc(input logic [3:0] i, input logic [15:0] e);
    wr(udb_pkg::OFS_SEL, {12'h000, i});
    rdr(udb_pkg::OFS_RDATA);
    chk("descriptor", {16'h0000, e}, rd);
  endtask
  task automatic tok(input logic dir, input udb_pkg::udb_hs_type hs,
                     input logic b);
    @(posedge clk);
    token_valid <= 1'b1;
    token_dir <= dir;
    @(posedge clk);
    token_valid <= 1'b0;
    #1;
    chk("resp_valid", 32'h1, {31'h0, resp_valid});
    chk("resp_hs", {30'h0, hs}, {30'h0, resp_hs});
    // buffer choice means nothing on a refused token
    if (hs < udb_pkg::HS_NAK) chk("buf", {31'h0, b}, {31'h0, resp_buf_sel});
    // refused tokens leave the transaction engine idle
    chk("busy", {31'h0, hs < udb_pkg::HS_NAK}, {31'h0, xact_busy});
  endtask
  task automatic done(input logic ok, c, o, input logic [15:0] n);
    @(posedge clk);
    xact_done <= 1'b1;
    xact_ok <= ok;
    crc_err <= c;
    overrun <= o;
    rx_count <= n;
    @(posedge clk);
    xact_done <= 1'b0;
    #1;
    chk("err_pulse", {31'h0, c}, {31'h0, err_pulse});
  endtask
  // ==================================================================
  // scenarios
  task automatic t_reset;
    st(16'hFFFF, udb_pkg::CTRL_RESET);
    rdr(8'h40);
    chk("unmapped resp", {30'h0, udb_pkg::RESP_SLVERR}, {30'h0, rr});
    wr(8'h40, 16'h0000);
    chk("unmapped bresp", {30'h0, udb_pkg::RESP_SLVERR}, {30'h0, rr});
    wr(udb_pkg::OFS_SEL, 16'h000F);
    rdr(udb_pkg::OFS_RDATA);
    chk("unused word", 32'h0, rd);
    $display("reset test done");
  endtask
  task automatic t_bulk;
    wr(udb_pkg::OFS_SEL, {12'h000, udb_pkg::IDX_RX1P});
    wr(udb_pkg::OFS_WDATA, 16'h0200);
    cwr(16'h3100);
    // a second direction on a swap endpoint must be dropped
    cwr(16'h0130);
    st(16'hFFFF, 16'h3100);
    wr(udb_pkg::OFS_INIT, 16'h0002);
    st(16'hFFFF, 16'h3140);
    tok(1'b0, udb_pkg::HS_ACK, 1'b0);
    done(1'b1, 1'b0, 1'b0, 16'h0040);
    st(16'hC0C0, 16'hC040);
    cwr({2'b00, rd[13:12] ^ 2'b11, 12'h100});
    st(16'hFFFF, 16'h7140);
    tok(1'b0, udb_pkg::HS_NAK, 1'b0);
    wr(udb_pkg::OFS_RELEASE, 16'h0001);
    tok(1'b0, udb_pkg::HS_ACK, 1'b1);
    chk("buf_ptr", 32'h0200, {16'h0, resp_buf_ptr});
    done(1'b1, 1'b0, 1'b0, 16'h0023);
    st(16'hFFFF, 16'hB100);
    dsc(udb_pkg::IDX_RX1L, 16'h0023);
    dsc(udb_pkg::IDX_RX0L, 16'h0040);
    tok(1'b0, udb_pkg::HS_NAK, 1'b0);
    cwr(16'h2100);
    tok(1'b0, udb_pkg::HS_STALL, 1'b0);
    $display("bulk test done");
  endtask
  task automatic t_iso;
    cwr(16'h1100);
    cwr(16'h0430);
    tok(1'b1, udb_pkg::HS_NONE, 1'b0);
    chk("data1", 32'h0, {31'h0, resp_data1});
    done(1'b1, 1'b0, 1'b0, 16'h0000);
    st(16'hFFFF, 16'h04F0);
    tok(1'b1, udb_pkg::HS_NONE, 1'b1);
    chk("data1", 32'h0, {31'h0, resp_data1});
    done(1'b1, 1'b0, 1'b0, 16'h0000);
    st(16'hFFFF, 16'h04B0);
    cwr(16'h0430);
    cwr(16'h3400);
    tok(1'b0, udb_pkg::HS_NONE, 1'b0);
    done(1'b0, 1'b1, 1'b0, 16'h0010);
    st(16'hFFFF, 16'hF400);
    // an overrun alone still completes and swaps, without an error
    tok(1'b0, udb_pkg::HS_NONE, 1'b1);
    done(1'b0, 1'b0, 1'b1, 16'h0011);
    st(16'hFFFF, 16'hB400);
    dsc(udb_pkg::IDX_RX1L, 16'h0011);
    $display("iso test done");
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    t_reset();
    t_bulk();
    t_iso();
    final_report();
  end
  // the whole run needs a few hundred cycles
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    final_report();
  end
endmodule
`default_nettype wire
